// ===== design/mq_port_options.sv
// Multi-queue FIFO with bus matching, null queue and shared almost-full bus.
`timescale 1ns/100ps
`include "mq_defines.svh"
module mq_port_options (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        width_match_enable,
  input  wire logic        input_width_sel,
  input  wire logic        output_width_sel,
  input  wire logic        flag_bus_mode_sel,
  input  wire logic        chip_identity_bit0,
  input  wire logic        chip_identity_bit1,
  input  wire logic        chip_identity_bit2,
  input  wire logic        write_en,
  input  wire logic [7:0]  write_queue_addr,
  input  wire logic [31:0] write_data,
  input  wire logic        tx_modulo_hi,
  input  wire logic        tx_modulo_lo,
  input  wire logic [1:0]  write_marker,
  output logic             active_full_n,
  output logic             active_full_oe_n,
  output logic             active_almost_full_n,
  input  wire logic        almost_full_bus_strobe,
  output logic      [7:0]  almost_full_bus,
  output logic      [1:0]  almost_full_bus_group,
  input  wire logic        read_addr_en,
  input  wire logic [4:0]  read_queue_addr,
  input  wire logic        read_en,
  output logic      [31:0] read_data,
  output logic             rx_modulo_hi,
  output logic             rx_modulo_lo,
  output logic      [1:0]  read_marker,
  output logic             output_valid_n
);

  mq_pkg::mq_state_t s;
  mq_pkg::mq_state_t n;
  logic [35:0]       din;
  logic [35:0]       wword;
  logic [35:0]       rd_word;
  logic [4:0]        wq;
  logic [6:0]        widx;
  logic [6:0]        ridx;
  logic [31:0]       af;
  logic [31:0]       empty;
  logic              dev_sel;
  logic              run;
  logic              null_on;
  logic              null_sel;
  logic              rq_has;
  logic              wr_ok;
  logic              push;
  logic              pop;
  logic              advance;

  function automatic logic [35:0] unit_of(input logic [35:0] w, input logic [1:0] u,
                                          input mq_pkg::mq_width_t m);
    case (m)
      mq_pkg::mq_w18: unit_of = {18'h0, w[18*u[0] +: 18]};
      mq_pkg::mq_w9:  unit_of = {27'h0, w[9*u +: 9]};
      default:        unit_of = w;
    endcase
  endfunction : unit_of

  // =========================================================
  // Pins and flags
  // =========================================================
  // Modulo bits ride in bits 32 and 33.
  assign din = {write_marker, tx_modulo_lo, tx_modulo_hi, write_data};
  // Low five address bits select the queue.
  assign wq = write_queue_addr[4:0];
  // Identity match, up to eight devices.
  assign dev_sel = write_queue_addr[7:5] == s.id;
  assign run = s.st == mq_pkg::mq_run;
  // Fewer than 32 queues frees queue 31 as null.
  assign null_on = s.nq != `MQ_NQ_MAX;

  assign prdata               = s.prdata;
  assign pready               = s.pready;
  assign pslverr              = s.pslverr;
  assign active_full_n        = s.ff_n;
  assign active_full_oe_n     = s.ff_oe_n;
  assign active_almost_full_n = s.paf_n;
  assign almost_full_bus      = s.afbus;
  assign almost_full_bus_group = s.afgrp;
  assign read_data            = s.rdata[31:0];
  // Stored modulo bits leave on bits 32 and 33 in 36-bit read mode; narrow reads give zero there.
  assign rx_modulo_hi         = s.rdata[32];
  assign rx_modulo_lo         = s.rdata[33];
  assign read_marker          = s.rdata[35:34];
  assign output_valid_n       = s.ov_n;

  // =========================================================
  // Next state
  // =========================================================
  always_comb
  begin
    n = s;
    push = 1'b0;
    pop = 1'b0;
    af = '0;
    empty = '0;
    wword = s.wacc;
    // Straps pass two flops before they are latched.
    n.s1 = {width_match_enable, input_width_sel, output_width_sel, flag_bus_mode_sel,
            chip_identity_bit2, chip_identity_bit1, chip_identity_bit0};
    n.s2 = s.s1;
    // Widths, flag mode and identity latched once.
    case (s.st)
      mq_pkg::mq_sync0: n.st = mq_pkg::mq_sync1;
      mq_pkg::mq_sync1: n.st = mq_pkg::mq_latch;
      mq_pkg::mq_latch:
      begin
        n.st = mq_pkg::mq_run;
        // Width match off means 36 on both ports.
        if (s.s2[6] && s.s2[5])
          n.win = s.s2[4] ? mq_pkg::mq_w9 : mq_pkg::mq_w18;
        else
          n.win = mq_pkg::mq_w36;
        if (s.s2[6] && !s.s2[5])
          n.wout = s.s2[4] ? mq_pkg::mq_w9 : mq_pkg::mq_w18;
        else
          n.wout = mq_pkg::mq_w36;
        n.fm = s.s2[3];
        n.id = s.s2[2:0];
      end
      default: n.st = mq_pkg::mq_run;
    endcase

    // Full means four packed 36-bit words in the queue, at any write width.
    wr_ok = run && write_en && dev_sel && ({1'b0, wq} < s.nq) && s.cnt[wq] != `MQ_DEPTH;
    // Units fill the long word from the low end.
    case (s.win)
      mq_pkg::mq_w18: wword[18*s.wu[0] +: 18] = din[17:0];
      mq_pkg::mq_w9:  wword[9*s.wu +: 9] = din[8:0];
      default:        wword = din;
    endcase
    // One packing register serves the write port, so a queue switch in the
    // middle of a long word sends the finished word to the new queue.
    if (wr_ok)
    begin
      if (s.wu == 2'(s.win))
      begin
        push = 1'b1;
        n.wu = 2'h0;
        n.wacc = '0;
      end
      else
      begin
        n.wacc = wword;
        n.wu = s.wu + 2'h1;
      end
    end
    widx = {wq, 2'(s.head[wq] + 2'(s.cnt[wq]))};
    if (push)
      n.mem[widx] = wword;

    // Null queue is only tested on the read side.
    null_sel = null_on && s.rsel == `MQ_NULL_Q;
    ridx = {s.rsel, s.head[s.rsel]};
    rd_word = s.mem[ridx];
    // Null queue never offers a word.
    rq_has = !null_sel && s.cnt[s.rsel] != 3'h0;
    // An empty output register refills on its own.
    advance = run && (s.ov_n || read_en);
    if (advance)
    begin
      // Each read takes one read-width unit.
      if (!s.ov_n && s.ru != 2'(s.wout))
        n.ru = s.ru + 2'h1;
      // Next word loads in the same edge as the read.
      else if (rq_has)
      begin
        pop = 1'b1;
        n.rword = rd_word;
        n.ru = 2'h0;
        n.ov_n = 1'b0;
      end
      // Empty or null queue: word held, valid high.
      else
        n.ov_n = 1'b1;
    end
    // Reselecting leaves the held word on the output.
    if (read_addr_en)
      n.rsel = read_queue_addr;
    n.rdata = unit_of(n.rword, n.ru, s.wout);

    for (int q = 0; q < `MQ_NQ; q++)
    begin
      n.cnt[q] = s.cnt[q] + 3'(push && wq == 5'(q)) - 3'(pop && s.rsel == 5'(q));
      if (pop && s.rsel == 5'(q))
        n.head[q] = s.head[q] + 2'h1;
      // Every queue keeps its own almost-full state.
      af[q] = n.cnt[q] >= `MQ_AF_LEVEL;
      empty[q] = s.cnt[q] == 3'h0;
    end
    n.ff_n = n.cnt[wq] != `MQ_DEPTH;
    n.paf_n = !af[wq];
    // Full flag driven only by the selected device.
    n.ff_oe_n = !dev_sel;

    // Small configurations keep group zero fixed.
    if (s.nq <= `MQ_NQ_DED)
      n.afgrp = 2'h0;
    // Polled mode steps through the groups.
    else if (s.fm)
      n.afgrp = s.afgrp + 2'h1;
    // Direct mode takes the group from the address.
    else if (almost_full_bus_strobe && dev_sel)
      n.afgrp = wq[4:3];
    n.afbus = ~af[8*n.afgrp +: 8];

    // Read data is captured one cycle ahead so prdata comes from a flop.
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      n.pready = 1'b1;
      if (paddr == `MQ_REG_CTRL)
        n.prdata = {26'h0, s.nq};
      else if (paddr == `MQ_REG_STAT)
        n.prdata = {22'h0, s.id, s.fm, s.wout, s.win, null_on, s.ov_n};
      else if (paddr == `MQ_REG_EMPTY)
        n.prdata = empty;
      else
      begin
        n.prdata = 32'h0;
        n.pslverr = 1'b1;
      end
    end
    if (psel && penable && s.pready && pwrite && paddr == `MQ_REG_CTRL &&
        pwdata[31:6] == 26'h0 && pwdata[5:0] != 6'h00 && pwdata[5:0] <= `MQ_NQ_MAX)
      n.nq = pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.nq <= `MQ_NQ_RST;
      s.ov_n <= 1'b1;
      s.ff_n <= 1'b1;
      s.paf_n <= 1'b1;
      s.ff_oe_n <= 1'b1;
      s.afbus <= `MQ_AFBUS_RST;
    end
    else
      s <= n;
  end

  // =========================================================
  // Checks
  // =========================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_mod_pass;
    pop && s.wout == mq_pkg::mq_w36 |=> {rx_modulo_lo, rx_modulo_hi} == $past(rd_word[33:32]);
  endproperty
  a_mod_pass: assert property (p_mod_pass)
    else $error("modulo bits altered");

  property p_fwft;
    run && output_valid_n && rq_has |=> !output_valid_n;
  endproperty
  a_fwft: assert property (p_fwft)
    else $error("waiting word did not fall to output");

  property p_stream;
    run && !output_valid_n && read_en && rq_has && s.wout == mq_pkg::mq_w36
      |=> !output_valid_n;
  endproperty
  a_stream: assert property (p_stream)
    else $error("read bus left idle");

  property p_null_empty;
    null_sel |-> !pop;
  endproperty
  a_null_empty: assert property (p_null_empty)
    else $error("null queue gave a word");

  property p_null_hold;
    null_sel && output_valid_n |=> output_valid_n && $stable(read_data);
  endproperty
  a_null_hold: assert property (p_null_hold)
    else $error("output changed on null queue");

  property p_ident;
    dev_sel |=> !active_full_oe_n;
  endproperty
  a_ident: assert property (p_ident)
    else $error("selected device not driving full flag");

  property p_unsel;
    !dev_sel |-> !push;
  endproperty
  a_unsel: assert property (p_unsel)
    else $error("write taken by unselected device");

  property p_full;
    s.cnt[wq] == `MQ_DEPTH |-> !push;
  endproperty
  a_full: assert property (p_full)
    else $error("write into full queue");

  property p_pack;
    s.win == mq_pkg::mq_w9 && wr_ok && s.wu != 2'h3 |-> !push;
  endproperty
  a_pack: assert property (p_pack)
    else $error("long word stored before four units");

  property p_unit;
    !output_valid_n && read_en && s.ru != 2'(s.wout) |-> !pop;
  endproperty
  a_unit: assert property (p_unit)
    else $error("word popped before all units read");

  property p_ded;
    run && s.nq <= `MQ_NQ_DED |=> almost_full_bus_group == 2'h0;
  endproperty
  a_ded: assert property (p_ded)
    else $error("dedicated bus not on group zero");

  property p_poll;
    s.nq > `MQ_NQ_DED && s.fm |=> almost_full_bus_group == $past(almost_full_bus_group) + 2'h1;
  endproperty
  a_poll: assert property (p_poll)
    else $error("polled group did not advance");

  property p_direct;
    s.nq > `MQ_NQ_DED && !s.fm && almost_full_bus_strobe && dev_sel
      |=> almost_full_bus_group == $past(wq[4:3]);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct group not taken from address");

  property p_cfg;
    run |=> $stable({s.win, s.wout, s.fm, s.id});
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configuration changed after latch");

  property p_null_q;
    null_on |-> !(push && wq == `MQ_NULL_Q);
  endproperty
  a_null_q: assert property (p_null_q)
    else $error("null queue written");

  c_null: cover property (null_sel && !output_valid_n ##1 output_valid_n);
  c_switch: cover property (read_addr_en && pop ##1 pop);
  c_narrow: cover property (s.wout == mq_pkg::mq_w9 && pop ##4 pop);
  c_full: cover property (!active_full_n && !active_full_oe_n);

endmodule : mq_port_options

// ===== design/mq_defines.svh
// Constants of the multi-queue port options block.
`ifndef MQ_DEFINES_SVH
`define MQ_DEFINES_SVH
`define MQ_NQ 32
`define MQ_DEPTH 3'h4
`define MQ_AF_LEVEL 3'h3
`define MQ_NULL_Q 5'h1f
`define MQ_NQ_RST 6'h20
`define MQ_NQ_MAX 6'h20
`define MQ_NQ_DED 6'h08
`define MQ_REG_CTRL 12'h000
`define MQ_REG_STAT 12'h004
`define MQ_REG_EMPTY 12'h008
`define MQ_AFBUS_RST 8'hff
`endif

// ===== design/mq_pkg.sv
// Types of the multi-queue port options block.
`include "mq_defines.svh"
package mq_pkg;

  // =========================================================
  // Port widths and configuration sequence
  // =========================================================
  // The code of a width is also the index of its last narrow unit.
  typedef enum logic [1:0] {
    mq_w36 = 2'b00,
    mq_w18 = 2'b01,
    mq_w9  = 2'b11
  } mq_width_t;

  typedef enum logic [1:0] {
    mq_sync0 = 2'b00,
    mq_sync1 = 2'b01,
    mq_latch = 2'b11,
    mq_run   = 2'b10
  } mq_cfg_st_t;

  typedef struct packed {
    mq_cfg_st_t                    st;
    logic [6:0]                    s1;
    logic [6:0]                    s2;
    mq_width_t                     win;
    mq_width_t                     wout;
    logic                          fm;
    logic [2:0]                    id;
    logic [5:0]                    nq;
    logic [`MQ_NQ*4-1:0][35:0]     mem;
    logic [`MQ_NQ-1:0][1:0]        head;
    logic [`MQ_NQ-1:0][2:0]        cnt;
    logic [35:0]                   wacc;
    logic [1:0]                    wu;
    logic [4:0]                    rsel;
    logic [35:0]                   rword;
    logic [1:0]                    ru;
    logic                          ov_n;
    logic [35:0]                   rdata;
    logic                          ff_n;
    logic                          paf_n;
    logic                          ff_oe_n;
    logic [7:0]                    afbus;
    logic [1:0]                    afgrp;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } mq_state_t;

endpackage : mq_pkg

// ===== bench/mq_partner.sv
// Write-side and read-side controller model driving the multi-queue block.
`timescale 1ns/100ps
module mq_partner (
  input  wire logic        pclk,
  output logic             write_en,
  output logic [7:0]       write_queue_addr,
  output logic [35:0]      wword,
  output logic             read_addr_en,
  output logic [4:0]       read_queue_addr,
  output logic             read_en
);
  // ==========
  // Controller tasks
  initial
  begin
    write_en         = 1'b0;
    write_queue_addr = 8'h00;
    wword            = 36'h0;
    read_addr_en     = 1'b0;
    read_queue_addr  = 5'h00;
    read_en          = 1'b0;
  end

  // Full 36-bit words only, and the null queue is never a target.
  task automatic put(input logic [7:0] a, input logic [35:0] w);
    @(posedge pclk);
    write_en         <= 1'b1;
    write_queue_addr <= a;
    wword            <= w;
  endtask : put

  // Released data shows the inverse so stale values never look valid.
  task automatic idle;
    @(posedge pclk);
    write_en <= 1'b0;
    wword    <= ~wword;
  endtask : idle

  task automatic sel(input logic [4:0] q);
    @(posedge pclk);
    read_addr_en    <= 1'b1;
    read_queue_addr <= q;
    @(posedge pclk);
    read_addr_en    <= 1'b0;
    read_queue_addr <= ~q;
  endtask : sel

  task automatic rden(input logic v);
    @(posedge pclk);
    read_en <= v;
  endtask : rden
endmodule : mq_partner

// ===== bench/multi_queue_port_options_test.sv
// Self-checking testbench of the multi-queue port options block.
`timescale 1ns/100ps
`include "mq_defines.svh"
module multi_queue_port_options_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, write_en, read_addr_en, read_en;
  logic        width_match_enable = 1'b0;
  logic        flag_bus_mode_sel = 1'b1;
  logic        almost_full_bus_strobe = 1'b0;
  logic        input_width_sel, output_width_sel;
  logic [7:0]  write_queue_addr, almost_full_bus;
  logic [4:0]  read_queue_addr;
  logic [35:0] wword, w, last;
  logic        active_full_n, active_full_oe_n, active_almost_full_n;
  logic [1:0]  almost_full_bus_group, read_marker;
  logic [31:0] read_data, rd;
  logic        rx_modulo_hi, rx_modulo_lo, output_valid_n, er;
  logic [2:0]  id;
  logic [5:0]  nq = 6'h20;
  logic [35:0] mdl[32][$];
  integer      seed = 32'h63fd;
  integer      miscompares = 0;
  integer      n_checks = 0;
  integer      i;
  wire  [35:0] rword = {read_marker, rx_modulo_lo, rx_modulo_hi, read_data};

  always #25 pclk = ~pclk;
  always @(posedge pclk) almost_full_bus_strobe <= ~almost_full_bus_strobe;

  mq_port_options dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .width_match_enable, .input_width_sel,
    .output_width_sel, .flag_bus_mode_sel, .chip_identity_bit0(id[0]),
    .chip_identity_bit1(id[1]), .chip_identity_bit2(id[2]), .write_en,
    .write_queue_addr, .write_data(wword[31:0]), .tx_modulo_hi(wword[32]),
    .tx_modulo_lo(wword[33]), .write_marker(wword[35:34]), .active_full_n,
    .active_full_oe_n, .active_almost_full_n, .almost_full_bus_strobe,
    .almost_full_bus, .almost_full_bus_group, .read_addr_en, .read_queue_addr,
    .read_en, .read_data, .rx_modulo_hi, .rx_modulo_lo, .read_marker, .output_valid_n);

  mq_partner u_part (.pclk, .write_en, .write_queue_addr, .wword, .read_addr_en,
    .read_queue_addr, .read_en);

  // ==========
  // Compare and bus tasks
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // The model keeps only what a matching device with room would accept.
  task automatic wr(input logic [7:0] a);
    w = 36'({$random(seed), $random(seed)});
    u_part.put(a, w);
    if (a[7:5] == id && {1'b0, a[4:0]} < nq && mdl[a[4:0]].size() < 4)
      mdl[a[4:0]].push_back(w);
  endtask : wr

  // Waits start on the next falling edge so no output is read as it launches.
  task automatic wait_valid;
    i = 0;
    do
    begin
      @(negedge pclk);
      i++;
    end
    while (output_valid_n !== 1'b0 && i < 8);
    chk_flag(output_valid_n, 1'b0);
  endtask : wait_valid

  task automatic wait_group(input logic [1:0] g);
    i = 0;
    do
    begin
      @(negedge pclk);
      i++;
    end
    while (almost_full_bus_group !== g && i < 8);
    chk_data(almost_full_bus_group, g);
  endtask : wait_group

  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end

  // ==========
  // Main sequence
  initial
  begin
    id = 3'($random(seed));
    {input_width_sel, output_width_sel} = 2'($random(seed));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `MQ_REG_STAT, 32'h0);
    chk_data(rd, {22'h0, id, 1'b1, 4'h0, 1'b0, 1'b1});
    apb(1'b0, 12'h00c, 32'h0);
    chk_flag(er, 1'b1);
    wr({id ^ 3'h2, 5'h02});
    for (int k = 0; k < 5; k++)
      wr({id, 5'h02});
    u_part.idle();
    repeat (2) @(negedge pclk);
    chk_flag(active_full_n, 1'b0);
    chk_flag(active_almost_full_n, 1'b0);
    chk_flag(active_full_oe_n, 1'b0);
    wait_group(2'h0);
    chk_data(almost_full_bus, 8'hfb);
    @(negedge pclk);
    chk_data(almost_full_bus_group, 2'h1);
    wr({id ^ 3'h2, 5'h09});
    u_part.idle();
    repeat (2) @(negedge pclk);
    chk_flag(active_full_oe_n, 1'b1);
    u_part.sel(5'h02);
    u_part.rden(1'b1);
    wait_valid();
    while (mdl[2].size() > 0)
    begin
      chk_flag(output_valid_n, 1'b0);
      last = mdl[2].pop_front();
      chk_data(rword, last);
      @(negedge pclk);
    end
    chk_flag(output_valid_n, 1'b1);
    u_part.rden(1'b0);
    apb(1'b1, `MQ_REG_CTRL, 32'h1f);
    nq = 6'h1f;
    apb(1'b0, `MQ_REG_STAT, 32'h0);
    chk_flag(rd[1], 1'b1);
    wr({id, 5'h05});
    u_part.idle();
    u_part.sel(5'h05);
    wait_valid();
    last = mdl[5].pop_front();
    chk_data(rword, last);
    u_part.sel(`MQ_NULL_Q);
    u_part.rden(1'b1);
    u_part.rden(1'b0);
    repeat (4)
    begin
      @(negedge pclk);
      chk_flag(output_valid_n, 1'b1);
      chk_data(rword, last);
    end
    // A small single device keeps its almost-full bits on group zero.
    apb(1'b1, `MQ_REG_CTRL, 32'h8);
    nq = 6'h08;
    @(negedge pclk);
    repeat (2)
    begin
      @(negedge pclk);
      chk_data(almost_full_bus_group, 2'h0);
    end
    // Second power-up: direct flag bus, 36-bit writes and 9-bit reads.
    @(posedge pclk);
    presetn            <= 1'b0;
    width_match_enable <= 1'b1;
    input_width_sel    <= 1'b0;
    output_width_sel   <= 1'b1;
    flag_bus_mode_sel  <= 1'b0;
    id                 <= 3'($random(seed));
    nq = 6'h20;
    foreach (mdl[q])
      mdl[q].delete();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, `MQ_REG_STAT, 32'h0);
    chk_data(rd, {22'h0, id, 1'b0, 4'hc, 1'b0, 1'b1});
    for (int k = 0; k < 3; k++)
      wr({id, 5'h12});
    u_part.idle();
    wait_group(2'h2);
    chk_data(almost_full_bus, 8'hfb);
    u_part.sel(5'h12);
    u_part.rden(1'b1);
    wait_valid();
    while (mdl[18].size() > 0)
    begin
      last = mdl[18].pop_front();
      for (int k = 0; k < 4; k++)
      begin
        chk_data(rword, {27'h0, last[9*k +: 9]});
        @(negedge pclk);
      end
    end
    chk_flag(output_valid_n, 1'b1);
    u_part.rden(1'b0);
    tally_and_finish();
  end
endmodule : multi_queue_port_options_test
